// >>> logic/afm_pkg.sv
// Shared constants for the arithmetic fault monitor.
// Assumes one system clock and a scan step strobe from the scan sequencer.
package afm_pkg;

  // Width of a block number; zero is the null reference
  localparam int unsigned AFM_REF_W = 4;
  localparam int unsigned AFM_NUM_BLK = 15;
  localparam logic [AFM_REF_W-1:0] AFM_REF_NULL = 4'h0;

  // Fault kind selection codes
  localparam logic [1:0] AFM_KIND_ZERO = 2'h0;
  localparam logic [1:0] AFM_KIND_OVFL = 2'h1;
  localparam logic [1:0] AFM_KIND_EITHER = 2'h2;

  // Reset values
  localparam logic AFM_FLAG_RST = 1'b0;
  localparam logic AFM_STAT_RST = 1'b0;
  // Enable history resets high so a level held through reset is no edge
  localparam logic AFM_EN_HIST_RST = 1'b1;

  typedef enum logic {
    AFM_IDLE,
    AFM_ACTIVE
  } afm_state_t;

endpackage : afm_pkg

// >>> logic/afm_fault_if.sv
// Carrier between the fault selector and the monitor core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface afm_fault_if;
  logic hit;
  logic ref_valid;

  modport src (output hit, output ref_valid);
  modport dst (input hit, input ref_valid);
endinterface : afm_fault_if

// >>> logic/afm_status_hold.sv
// Holds the fault status of one arithmetic block from its last evaluation.
// Assumes eval_done is a one-cycle pulse on clk_sys from the arithmetic block.
`timescale 1ns/1ps
module afm_status_hold
  import afm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic eval_done,
  input wire logic divide_zero_flag,
  input wire logic overflow_flag,
  output logic latest_zero,
  output logic latest_ovfl
);

  logic zero_q;
  logic ovfl_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      zero_q <= AFM_STAT_RST;
      ovfl_q <= AFM_STAT_RST;
    end else if (eval_done) begin
      zero_q <= divide_zero_flag;
      ovfl_q <= overflow_flag;
    end
  end

  // Completion in the step cycle counts as earlier in the scan
  always_comb begin
    latest_zero = eval_done ? divide_zero_flag : zero_q;
    latest_ovfl = eval_done ? overflow_flag : ovfl_q;
  end

endmodule : afm_status_hold

// >>> logic/afm_fault_select.sv
// Picks the referenced block and the selected fault kind.
// Assumes status vectors are indexed by block number minus one.
`timescale 1ns/1ps
module afm_fault_select
  import afm_pkg::*;
#(
  parameter int unsigned NUM_BLK = AFM_NUM_BLK
) (
  input wire logic [NUM_BLK-1:0] zero_vec,
  input wire logic [NUM_BLK-1:0] ovfl_vec,
  input wire logic [AFM_REF_W-1:0] source_block_ref,
  input wire logic [1:0] fault_kind_sel,
  afm_fault_if.src fault
);

  logic zero_sel;
  logic ovfl_sel;
  logic valid;

  always_comb begin
    valid = (source_block_ref != AFM_REF_NULL)
      && ({28'h0, source_block_ref} <= NUM_BLK);
    zero_sel = 1'b0;
    ovfl_sel = 1'b0;
    for (int unsigned i = 0; i < NUM_BLK; i++) begin
      if (valid && ({28'h0, source_block_ref} == i + 1)) begin
        zero_sel = zero_vec[i];
        ovfl_sel = ovfl_vec[i];
      end
    end
    fault.ref_valid = valid;
    case (fault_kind_sel)
      AFM_KIND_ZERO: fault.hit = zero_sel;
      AFM_KIND_OVFL: fault.hit = ovfl_sel;
      AFM_KIND_EITHER: fault.hit = zero_sel | ovfl_sel;
      // Unused code never raises the flag
      default: fault.hit = 1'b0;
    endcase
  end

endmodule : afm_fault_select

// >>> logic/afm_monitor.sv
// Arithmetic fault monitor top: flags divide-by-zero and overflow of one block.
// Assumes all inputs come from logic on clk_sys; scan_step is a one-cycle pulse
// marking the monitor's place in each program scan.
//
// Behaviour
// - Start monitoring only on enable rising edge
// - Clear input forces flag low
// - Kind selection picks zero, overflow or either
// - Either selection ORs both status bits
// - Auto clear: flag shows newest status only
// - Without auto clear, flag sticks until clear
// - Earlier evaluation seen same scan, later next
// - Null source reference keeps flag zero
// - Flag follows latest completed evaluation status
// - Block number selects one arithmetic block
`timescale 1ns/1ps
module afm_monitor
  import afm_pkg::*;
#(
  parameter int unsigned NUM_BLK = AFM_NUM_BLK
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scan_step,
  input wire logic enable,
  input wire logic clear_in,
  input wire logic auto_clear_select,
  input wire logic [1:0] fault_kind_sel,
  input wire logic [AFM_REF_W-1:0] source_block_ref,
  input wire logic [NUM_BLK-1:0] eval_done,
  input wire logic [NUM_BLK-1:0] divide_zero_flag,
  input wire logic [NUM_BLK-1:0] overflow_flag,
  output logic fault_flag,
  output logic monitor_active
);

  logic [NUM_BLK-1:0] zero_vec;
  logic [NUM_BLK-1:0] ovfl_vec;
  logic en_hist_q;
  logic fault_flag_q;
  logic fault_flag_d;
  afm_state_t state_q;
  afm_fault_if fault ();

  // Separate status per block, as each block owns its own fault bits
  for (genvar g = 0; g < NUM_BLK; g++) begin : g_hold
    afm_status_hold u_hold (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .eval_done(eval_done[g]),
      .divide_zero_flag(divide_zero_flag[g]),
      .overflow_flag(overflow_flag[g]),
      .latest_zero(zero_vec[g]),
      .latest_ovfl(ovfl_vec[g])
    );
  end

  afm_fault_select #(
    .NUM_BLK(NUM_BLK)
  ) u_select (
    .zero_vec(zero_vec),
    .ovfl_vec(ovfl_vec),
    .source_block_ref(source_block_ref),
    .fault_kind_sel(fault_kind_sel),
    .fault(fault.src)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en_hist_q <= AFM_EN_HIST_RST;
    end else begin
      en_hist_q <= enable;
    end
  end

  // Dropping enable disarms; only a fresh edge re-arms
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= AFM_IDLE;
    end else begin
      case (state_q)
        AFM_IDLE: if (enable && !en_hist_q) state_q <= AFM_ACTIVE;
        AFM_ACTIVE: if (!enable) state_q <= AFM_IDLE;
        default: state_q <= AFM_IDLE;
      endcase
    end
  end

  always_comb begin
    fault_flag_d = fault_flag_q;
    if (scan_step && state_q == AFM_ACTIVE) begin
      if (auto_clear_select) begin
        fault_flag_d = fault.hit;
      end else begin
        fault_flag_d = fault_flag_q | fault.hit;
      end
    end
    // Clear beats a coincident fault, as the reset input is meant to
    if (clear_in) begin
      fault_flag_d = 1'b0;
    end
    if (!fault.ref_valid) begin
      fault_flag_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fault_flag_q <= AFM_FLAG_RST;
    end else begin
      fault_flag_q <= fault_flag_d;
    end
  end

  always_comb begin
    fault_flag = fault_flag_q;
    monitor_active = (state_q == AFM_ACTIVE);
  end

endmodule : afm_monitor

// >>> verif/afm_arith_model.sv
// Arithmetic blocks on the far side of the monitor.
// Assumes run pulses come from the bench on clk_sys.
`timescale 1ns/1ps
module afm_arith_model #(
  parameter int unsigned NB = 4
) (
  input wire logic clk_sys,
  input wire logic [NB-1:0] run,
  input wire logic z,
  input wire logic o,
  output logic [NB-1:0] eval_done,
  output logic [NB-1:0] divide_zero_flag,
  output logic [NB-1:0] overflow_flag
);
  // Stale status toggles, so it is never mistaken for fresh
  always @(posedge clk_sys) begin
    eval_done <= run;
    divide_zero_flag <= run & {NB{z}} | ~run & ~divide_zero_flag;
    overflow_flag <= run & {NB{o}} | ~run & ~overflow_flag;
  end
endmodule : afm_arith_model

// >>> verif/afm_monitor_checker.sv
// Assertions on the fault monitor ports.
// Assumes one clock domain; bound at the foot.
`timescale 1ns/1ps
module afm_monitor_checker
  import afm_pkg::*;
#(
  parameter int unsigned NUM_BLK = AFM_NUM_BLK
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scan_step,
  input wire logic enable,
  input wire logic clear_in,
  input wire logic auto_clear_select,
  input wire logic [AFM_REF_W-1:0] source_block_ref,
  input wire logic fault_flag,
  input wire logic monitor_active
);
  logic ok;
  assign ok = source_block_ref != AFM_REF_NULL && source_block_ref <= NUM_BLK;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_clr; clear_in |=> !fault_flag; endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_nul; !ok |=> !fault_flag; endproperty
  a_nul: assert property (p_nul) else $error("nul");
  property p_arm; $rose(enable) && $past(rst_n) |=> monitor_active; endproperty
  a_arm: assert property (p_arm) else $error("arm");
  property p_his; !monitor_active && !$rose(enable) |=> !monitor_active; endproperty
  a_his: assert property (p_his) else $error("his");
  property p_off; !enable |=> !monitor_active; endproperty
  a_off: assert property (p_off) else $error("off");
  property p_fal; $fell(monitor_active) |-> !$past(enable); endproperty
  a_fal: assert property (p_fal) else $error("fal");
  property p_hld;
    !(scan_step && monitor_active) && !clear_in && ok |=> $stable(fault_flag);
  endproperty
  a_hld: assert property (p_hld) else $error("hld");
  property p_stk; fault_flag && !auto_clear_select && !clear_in && ok |=> fault_flag; endproperty
  a_stk: assert property (p_stk) else $error("stk");
  c_set: cover property (fault_flag);
  c_arm: cover property ($rose(monitor_active));
  c_clr: cover property (clear_in && fault_flag);
endmodule : afm_monitor_checker
bind afm_monitor afm_monitor_checker #(.NUM_BLK(NUM_BLK)) i_chk (.clk_sys, .rst_n, .scan_step,
  .enable, .clear_in, .auto_clear_select, .source_block_ref, .fault_flag, .monitor_active);

// >>> verif/tb_top.sv
// Bench for the fault monitor: kind table, then hand cases.
// Assumes the model and the bound checker compile first.
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t %h %h", $time, a, e); end end
module tb_top;
  logic clk_sys = 1'b0, rst_n = 1'b0, scan_step = 1'b0, enable = 1'b1, clear_in = 1'b0;
  logic auto_clear_select = 1'b1, z = 1'b0, o = 1'b0, fault_flag, monitor_active;
  logic [1:0] fault_kind_sel = 2'h0;
  logic [3:0] source_block_ref = 4'h3, run = 4'h0, eval_done, divide_zero_flag, overflow_flag;
  int error_cnt = 0, total_checks = 0;
  // Kind, zero, overflow, expected flag
  logic [4:0] rows [9] = '{5'h05, 5'h02, 5'h0C, 5'h0B, 5'h15, 5'h13, 5'h17, 5'h10, 5'h1E};
  afm_arith_model #(.NB(4)) i_arith (.clk_sys, .run, .z, .o, .eval_done, .divide_zero_flag,
    .overflow_flag);
  afm_monitor #(.NUM_BLK(4)) i_dut (.clk_sys, .rst_n, .scan_step, .enable, .clear_in,
    .auto_clear_select, .fault_kind_sel, .source_block_ref, .eval_done, .divide_zero_flag,
    .overflow_flag, .fault_flag, .monitor_active);
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // A late evaluation lands after the step, so it shows one scan later
  task automatic step(input int b, input logic [1:0] k, input logic zz, oo, late);
    @(posedge clk_sys);
    run <= 4'h1 << b;
    fault_kind_sel <= k;
    z <= zz;
    o <= oo;
    scan_step <= late;
    @(posedge clk_sys);
    run <= 4'h0;
    scan_step <= !late;
    @(posedge clk_sys);
    scan_step <= 1'b0;
    #1;
  endtask : step
  initial forever #12.5 clk_sys = ~clk_sys;
  initial begin
    repeat (2000) @(posedge clk_sys);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys) enable <= 1'b0;
    #1 `CHK(monitor_active, 1'b0)
    `CHK(fault_flag, 1'b0)
    @(posedge clk_sys) enable <= 1'b1;
    @(posedge clk_sys) #1 `CHK(monitor_active, 1'b1)
    $display("arm done");
    foreach (rows[i]) begin
      step(2, rows[i][4:3], rows[i][2], rows[i][1], 1'b0);
      `CHK(fault_flag, rows[i][0])
    end
    $display("kind table done");
    @(posedge clk_sys) auto_clear_select <= 1'b0;
    step(2, 2'h0, 1'b1, 1'b0, 1'b0);
    step(2, 2'h0, 1'b0, 1'b0, 1'b0);
    `CHK(fault_flag, 1'b1)
    @(posedge clk_sys) clear_in <= 1'b1;
    @(posedge clk_sys) clear_in <= 1'b0;
    #1 `CHK(fault_flag, 1'b0)
    step(1, 2'h0, 1'b1, 1'b1, 1'b0);
    `CHK(fault_flag, 1'b0)
    $display("sticky done");
    @(posedge clk_sys) auto_clear_select <= 1'b1;
    step(2, 2'h0, 1'b1, 1'b0, 1'b1);
    `CHK(fault_flag, 1'b0)
    step(1, 2'h0, 1'b0, 1'b0, 1'b0);
    `CHK(fault_flag, 1'b1)
    @(posedge clk_sys) source_block_ref <= 4'h0;
    enable <= 1'b0;
    step(2, 2'h0, 1'b1, 1'b0, 1'b0);
    `CHK(fault_flag, 1'b0)
    `CHK(monitor_active, 1'b0)
    $display("late, null and disarm done");
    tally_and_finish();
  end
endmodule : tb_top
